// >>> rtl/status_bank_pkg.sv
// status bank package: register offsets, bit positions, reset values
// assumes a byte-wide register read port supplied by the serial front end
package status_bank_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          COMP_W        = 16;

  // register offsets
  localparam logic [7:0]  REGULATION_OFS = 8'h00;
  localparam logic [7:0]  FAULT_TEMP_OFS = 8'h01;
  localparam logic [7:0]  ALARM_OFS      = 8'h02;
  localparam logic [7:0]  CHANGE_OFS     = 8'h03;

  // charger_regulation_status bits
  localparam int          TAPER_BIT      = 6;
  localparam int          DONE_BIT       = 5;
  localparam int          ICL_BIT        = 4;
  localparam int          PPATH_BIT      = 3;
  localparam int          VLIM_BIT       = 2;
  localparam int          THERM_BIT      = 1;
  localparam int          PGOOD_BIT      = 0;

  // fault_temperature_status bits
  localparam int          OVP_BIT        = 7;
  localparam int          OCP_BIT        = 5;
  localparam int          BUV_BIT        = 4;
  localparam int          COLD_BIT       = 3;
  localparam int          COOL_BIT       = 2;
  localparam int          WARM_BIT       = 1;
  localparam int          HOT_BIT        = 0;

  // converter_alarm_status bits
  localparam int          COMP1_BIT      = 6;
  localparam int          COMP2_BIT      = 5;
  localparam int          COMP3_BIT      = 4;
  localparam int          OPEN_BIT       = 0;

  // companion change latch bit
  localparam int          PCHG_BIT       = 0;

  // reset values (status content is live, so zero is a safe start)
  localparam logic [7:0]  STAT_RST       = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

endpackage

// >>> rtl/threshold_compare.sv
// one adc alarm comparator: measurement against threshold, direction selectable
// assumes measurement and threshold are synchronous to mclk
`timescale 1ns/10ps
module threshold_compare #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // comparison operands
  input  wire logic [W-1:0] measurement,
  input  wire logic [W-1:0] threshold,
  input  wire logic         above,
  // result
  output logic              alarm
);

  logic alarm_r;
  logic alarm_nxt;

  always_comb begin
    // above selects measurement > threshold, else measurement < threshold
    if (above) begin
      alarm_nxt = (measurement > threshold);
    end else begin
      alarm_nxt = (measurement < threshold);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  assign alarm = alarm_r;

endmodule // threshold_compare

// >>> rtl/charger_status_registers.sv
// live status register bank of a single-cell charge manager
// assumes condition inputs synchronous to mclk and a byte read port
// driven by the serial register front end (one-cycle rd_en strobe)
`timescale 1ns/10ps

// Functional notes
// - three read-only live status bytes at offsets 0x0, 0x1, 0x2
// - regulation bit 6 is one while in constant-voltage taper mode
// - regulation bits 5..1: done, current limit, power path, voltage limit, thermal
// - bit 0 one only when input above uvlo, above battery plus offset, below ovp
// - fault bit 7 shows input overvoltage; bit 6 reserved
// - fault bit 5 shows battery overcurrent protection active
// - fault bit 4 one while battery below undervoltage lockout level
// - fault bit 2 one while thermistor between cool and cold thresholds
// - fault bit 1 one while thermistor between warm and hot thresholds
// - alarm bits 6,5,4 one while comparators one,two,three meet condition
// - comparator bit reads zero when its condition is not met
// - alarm bit 0 one while thermistor above open level; 7, 3..1 reserved
// - power-valid change latches a flag, cleared by reading its register
module charger_status_registers
  import status_bank_pkg::*;
#(
  parameter int COMP_WIDTH = status_bank_pkg::COMP_W
) (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                reset,
  // register read port
  input  wire logic                                rd_en,
  input  wire logic [status_bank_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [status_bank_pkg::DATA_W-1:0]  rd_data,
  output logic                                     rd_valid,
  // regulation conditions
  input  wire logic                                taper_mode_active,
  input  wire logic                                charge_done,
  input  wire logic                                input_current_limiting,
  input  wire logic                                power_path_limiting,
  input  wire logic                                input_voltage_limiting,
  input  wire logic                                thermal_regulating,
  // input supply comparators
  input  wire logic                                input_above_uvlo,
  input  wire logic                                input_above_battery_sleep,
  input  wire logic                                input_below_ovp,
  // faults
  input  wire logic                                input_overvoltage,
  input  wire logic                                battery_overcurrent,
  input  wire logic                                battery_undervoltage,
  // thermistor comparators
  input  wire logic                                thermistor_above_cold,
  input  wire logic                                thermistor_above_cool,
  input  wire logic                                thermistor_below_warm,
  input  wire logic                                thermistor_below_hot,
  input  wire logic                                thermistor_above_open,
  // adc comparator operands
  input  wire logic [COMP_WIDTH-1:0]               comparator_one_meas,
  input  wire logic [COMP_WIDTH-1:0]               comparator_two_meas,
  input  wire logic [COMP_WIDTH-1:0]               comparator_three_meas,
  input  wire logic [COMP_WIDTH-1:0]               comparator_one_thresh,
  input  wire logic [COMP_WIDTH-1:0]               comparator_two_thresh,
  input  wire logic [COMP_WIDTH-1:0]               comparator_three_thresh,
  input  wire logic                                comparator_one_direction,
  input  wire logic                                comparator_two_direction,
  input  wire logic                                comparator_three_direction,
  // live power-valid level
  output logic                                     input_power_valid
);

  import status_bank_pkg::*;

  logic [7:0] regulation_r;
  logic [7:0] regulation_nxt;
  logic [7:0] fault_temp_r;
  logic [7:0] fault_temp_nxt;
  logic [7:0] alarm_nxt;
  logic       pgood_prev_r;
  logic       pgood_prev_nxt;
  logic       pchg_latch_r;
  logic       pchg_latch_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;
  logic       comp_one;
  logic       comp_two;
  logic       comp_three;
  logic       pgood_now;
  logic       change_rd;

  // adc alarm comparators
  threshold_compare #(.W(COMP_WIDTH)) u_comp_one (
    .mclk        (mclk),
    .reset       (reset),
    .measurement (comparator_one_meas),
    .threshold   (comparator_one_thresh),
    .above       (comparator_one_direction),
    .alarm       (comp_one)
  );

  threshold_compare #(.W(COMP_WIDTH)) u_comp_two (
    .mclk        (mclk),
    .reset       (reset),
    .measurement (comparator_two_meas),
    .threshold   (comparator_two_thresh),
    .above       (comparator_two_direction),
    .alarm       (comp_two)
  );

  threshold_compare #(.W(COMP_WIDTH)) u_comp_three (
    .mclk        (mclk),
    .reset       (reset),
    .measurement (comparator_three_meas),
    .threshold   (comparator_three_thresh),
    .above       (comparator_three_direction),
    .alarm       (comp_three)
  );

  assign pgood_now = input_above_uvlo & input_above_battery_sleep & input_below_ovp;

  // live status capture
  always_comb begin
    regulation_nxt            = STAT_RST;
    regulation_nxt[TAPER_BIT] = taper_mode_active;
    regulation_nxt[DONE_BIT]  = charge_done;
    regulation_nxt[ICL_BIT]   = input_current_limiting;
    regulation_nxt[PPATH_BIT] = power_path_limiting;
    regulation_nxt[VLIM_BIT]  = input_voltage_limiting;
    regulation_nxt[THERM_BIT] = thermal_regulating;
    regulation_nxt[PGOOD_BIT] = pgood_now;
  end

  // fault and thermistor region byte
  always_comb begin
    fault_temp_nxt            = STAT_RST;
    fault_temp_nxt[OVP_BIT]   = input_overvoltage;
    fault_temp_nxt[OCP_BIT]   = battery_overcurrent;
    fault_temp_nxt[BUV_BIT]   = battery_undervoltage;
    fault_temp_nxt[COLD_BIT]  = thermistor_above_cold;
    fault_temp_nxt[COOL_BIT]  = thermistor_above_cool & ~thermistor_above_cold;
    fault_temp_nxt[WARM_BIT]  = thermistor_below_warm & ~thermistor_below_hot;
    fault_temp_nxt[HOT_BIT]   = thermistor_below_hot;
  end

  // alarm byte: comparator bits read straight from the comparator flops, open bit from the live thermistor_above_open input
  always_comb begin
    alarm_nxt                 = STAT_RST;
    alarm_nxt[COMP1_BIT]      = comp_one;
    alarm_nxt[COMP2_BIT]      = comp_two;
    alarm_nxt[COMP3_BIT]      = comp_three;
    alarm_nxt[OPEN_BIT]       = thermistor_above_open;
  end

  // read of the change latch clears it
  assign change_rd = rd_en && (rd_addr == CHANGE_OFS);

  // power-valid change latch; a change in the clearing cycle wins
  always_comb begin
    pgood_prev_nxt = regulation_r[PGOOD_BIT];
    pchg_latch_nxt = pchg_latch_r;
    if (change_rd) begin
      pchg_latch_nxt = 1'b0;
    end
    if (regulation_r[PGOOD_BIT] != pgood_prev_r) begin
      pchg_latch_nxt = 1'b1;
    end
  end

  // read decode; status reads change nothing
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = rd_en;
    if (rd_en) begin
      if (rd_addr == REGULATION_OFS) begin
        rd_data_nxt = regulation_r;
      end else if (rd_addr == FAULT_TEMP_OFS) begin
        rd_data_nxt = fault_temp_r;
      end else if (rd_addr == ALARM_OFS) begin
        rd_data_nxt = alarm_nxt;
      end else if (rd_addr == CHANGE_OFS) begin
        rd_data_nxt           = UNMAPPED_DATA;
        rd_data_nxt[PCHG_BIT] = pchg_latch_r;
      end else begin
        rd_data_nxt = UNMAPPED_DATA;
      end
    end
  end

  // live status registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      regulation_r <= STAT_RST;
      fault_temp_r <= STAT_RST;
    end else begin
      regulation_r <= regulation_nxt;
      fault_temp_r <= fault_temp_nxt;
    end
  end

  // change latch and its history bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      pgood_prev_r <= 1'b0;
      pchg_latch_r <= 1'b0;
    end else begin
      pgood_prev_r <= pgood_prev_nxt;
      pchg_latch_r <= pchg_latch_nxt;
    end
  end

  // read answer registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_r    <= STAT_RST;
      rd_valid_r   <= 1'b0;
    end else begin
      rd_data_r    <= rd_data_nxt;
      rd_valid_r   <= rd_valid_nxt;
    end
  end

  assign rd_data           = rd_data_r;
  assign rd_valid          = rd_valid_r;
  assign input_power_valid = regulation_r[PGOOD_BIT];

endmodule // charger_status_registers

// >>> verification/charger_status_registers_properties.sv
// checker: read port timing and live status bytes of the status bank
// assumes it is bound into charger_status_registers, single mclk domain
`timescale 1ns/10ps
module charger_status_registers_properties
  import status_bank_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // read port
  input wire logic       rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  // watched conditions
  input wire logic       taper_mode_active,
  input wire logic       input_above_uvlo,
  input wire logic       input_above_battery_sleep,
  input wire logic       input_below_ovp,
  input wire logic       input_overvoltage,
  input wire logic       thermistor_above_cold,
  input wire logic       thermistor_above_cool,
  input wire logic       thermistor_below_warm,
  input wire logic       thermistor_below_hot,
  input wire logic       input_power_valid
);
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  logic       pg_in;
  logic       cool_in;
  logic       warm_in;
  assign pg_in   = input_above_uvlo & input_above_battery_sleep & input_below_ovp;
  assign cool_in = thermistor_above_cool & ~thermistor_above_cold;
  assign warm_in = thermistor_below_warm & ~thermistor_below_hot;
  // warm-up so that two-deep history never reaches into reset
  always_comb up_nxt = reset ? 2'h0 : (up_r == 2'h3) ? up_r : up_r + 2'h1;
  always_ff @(posedge mclk) up_r <= up_nxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || up_r != 2'h3);
  read_answered_a: assert property (rd_en |=> rd_valid)
    else $error("read strobe not answered next cycle");
  idle_data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved without a read");
  taper_bit_a: assert property (rd_en && rd_addr == REGULATION_OFS |=>
    rd_data[TAPER_BIT] == $past(taper_mode_active, 2)) else $error("taper bit wrong");
  pgood_bit_a: assert property (rd_en && rd_addr == REGULATION_OFS |=>
    rd_data[PGOOD_BIT] == $past(pg_in, 2)) else $error("power good bit wrong");
  live_pgood_a: assert property (input_power_valid == $past(pg_in))
    else $error("live power good wrong");
  overvolt_bit_a: assert property (rd_en && rd_addr == FAULT_TEMP_OFS |=>
    rd_data[OVP_BIT] == $past(input_overvoltage, 2) && !rd_data[6])
    else $error("overvoltage byte wrong");
  cool_warm_a: assert property (rd_en && rd_addr == FAULT_TEMP_OFS |=>
    rd_data[COOL_BIT] == $past(cool_in, 2) && rd_data[WARM_BIT] == $past(warm_in, 2))
    else $error("cool or warm bit wrong");
  alarm_reserved_a: assert property (rd_en && rd_addr == ALARM_OFS |=>
    !rd_data[7] && rd_data[3:1] == 3'h0) else $error("reserved alarm bits set");
  unmapped_zero_a: assert property (rd_en && rd_addr > CHANGE_OFS |=>
    rd_data == 8'h00) else $error("unmapped read not zero");
endmodule // charger_status_registers_properties

bind charger_status_registers charger_status_registers_properties u_props (
  .mclk, .reset, .rd_en, .rd_addr, .rd_data, .rd_valid, .taper_mode_active,
  .input_above_uvlo, .input_above_battery_sleep, .input_below_ovp, .input_overvoltage,
  .thermistor_above_cold, .thermistor_above_cool, .thermistor_below_warm,
  .thermistor_below_hot, .input_power_valid);

// >>> verification/status_host_model.sv
// host model: single-byte reads on the status read port
// assumes the bench calls read() from one thread at a time
`timescale 1ns/10ps
module status_host_model (
  // clock
  input  wire logic       mclk,
  // read port
  output logic            rd_en,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end
  task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_en   <= 1'b0;
    // released address toggles so a stale copy is never trusted
    rd_addr <= ~a;
    for (int n = 0; n < 3 && !ok; n++) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) begin
        d  = rd_data;
        ok = 1'b1;
      end
    end
  endtask
endmodule // status_host_model

// >>> verification/charger_status_registers_tb.sv
// bench: random live conditions, status reads, change latch, unmapped reads
// assumes status_host_model drives reads and the checker is bound
`timescale 1ns/10ps
module charger_status_registers_tb;
  import status_bank_pkg::*;
  logic        mclk, reset, rd_en, rd_valid, input_power_valid, lx;
  logic [7:0]  rd_addr, rd_data, d;
  logic [19:0] c;
  logic [15:0] m [3];
  logic [15:0] t [3];
  logic [31:0] r;
  bit          ok;
  int          errors, samples_checked;
  charger_status_registers u_charger_status_registers (
    .mclk, .reset, .rd_en, .rd_addr, .rd_data, .rd_valid, .input_power_valid,
    .taper_mode_active(c[0]), .charge_done(c[1]), .input_current_limiting(c[2]),
    .power_path_limiting(c[3]), .input_voltage_limiting(c[4]), .thermal_regulating(c[5]),
    .input_above_uvlo(c[6]), .input_above_battery_sleep(c[7]), .input_below_ovp(c[8]),
    .input_overvoltage(c[9]), .battery_overcurrent(c[10]), .battery_undervoltage(c[11]),
    .thermistor_above_cold(c[12]), .thermistor_above_cool(c[13]),
    .thermistor_below_warm(c[14]), .thermistor_below_hot(c[15]),
    .thermistor_above_open(c[16]), .comparator_one_meas(m[0]), .comparator_two_meas(m[1]),
    .comparator_three_meas(m[2]), .comparator_one_thresh(t[0]),
    .comparator_two_thresh(t[1]), .comparator_three_thresh(t[2]),
    .comparator_one_direction(c[17]), .comparator_two_direction(c[18]),
    .comparator_three_direction(c[19]));
  status_host_model u_status_host_model (.mclk, .rd_en, .rd_addr, .rd_data, .rd_valid);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic hit(int i);
    return c[17+i] ? m[i] > t[i] : m[i] < t[i];
  endfunction
  function automatic logic [7:0] exp_byte(logic [7:0] a);
    case (a)
      8'h00: return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], c[6] & c[7] & c[8]};
      8'h01: return {c[9], 1'b0, c[10], c[11], c[12], c[13] & ~c[12], c[14] & ~c[15], c[15]};
      8'h02: return {1'b0, hit(0), hit(1), hit(2), 3'h0, c[16]};
      8'h03: return {7'h00, lx};
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_read(logic [7:0] a);
    u_status_host_model.read(a, d, ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end else begin
      cmp($sformatf("offset %h", a), exp_byte(a), d);
    end
  endtask
  task automatic settle(logic [2:0] pg);
    @(posedge mclk);
    c[8:6] <= pg;
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    reset = 1'b1;
    c = '0;
    lx = 1'b0;
    foreach (m[i]) begin
      m[i] = 16'h0000;
      t[i] = 16'h0000;
    end
    r = $urandom(32'h2BF75F29);
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (int k = 0; k < 60; k++) begin
      @(posedge mclk);
      r = $urandom;
      c <= r[19:0];
      // equal, off-by-one and free thresholds
      for (int i = 0; i < 3; i++) begin
        r = $urandom;
        m[i] <= r[15:0];
        t[i] <= (k % 3 == 0) ? r[15:0] : (k % 3 == 1) ? r[15:0] + 16'h0001 : r[31:16];
      end
      repeat (3) @(posedge mclk);
      chk_read(8'h00);
      chk_read(8'h01);
      chk_read(8'h02);
      cmp("power valid", {7'h00, c[6] & c[7] & c[8]}, {7'h00, input_power_valid});
    end
    $display("random status sweep done");
    settle(3'h0);
    // flush whatever the random sweep left in the change latch
    u_status_host_model.read(8'h03, d, ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end else begin
      chk_read(8'h03);
    end
    settle(3'h7);
    lx = 1'b1;
    chk_read(8'h03);
    lx = 1'b0;
    chk_read(8'h03);
    settle(3'h6);
    lx = 1'b1;
    chk_read(8'h03);
    lx = 1'b0;
    // clearing read taken in the very cycle the latch sets: set wins
    @(posedge mclk);
    c[8:6] <= 3'h7;
    chk_read(8'h03);
    lx = 1'b1;
    chk_read(8'h03);
    lx = 1'b0;
    chk_read(8'h00);
    chk_read(8'h00);
    $display("change latch test done");
    for (int a = 4; a < 256; a += 61) chk_read(a[7:0]);
    $display("unmapped read test done");
    wrap_up();
  end
endmodule // charger_status_registers_tb
